// *** shared/pmb_pkg.sv ***
// Package: register map, reset values and constants of the pin mux / boot mode block
`default_nettype none
package pmb_pkg;
	// APB register byte offsets
	localparam logic [7:0] SYSOPT_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF   = 8'h04;
	localparam logic [7:0] FUNCSEL_OFF  = 8'h08;
	localparam logic [7:0] PADCFG_OFF   = 8'h0C;
	localparam logic [7:0] PORTOUT_OFF  = 8'h10;
	localparam logic [7:0] PORTDIR_OFF  = 8'h14;
	localparam logic [7:0] PORTIN_OFF   = 8'h18;
	localparam logic [7:0] DBGCMD_OFF   = 8'h1C;
	// system_options field positions
	localparam int RST_PIN_EN_BIT = 0;
	localparam int BKG_PIN_EN_BIT = 1;
	// Status field positions
	localparam int ST_BKG_MODE_BIT = 0;
	localparam int ST_MS_CAPT_BIT  = 1;
	localparam int ST_RST_PIN_BIT  = 2;
	// Debug command field positions
	localparam int DC_GO_BIT    = 0;
	localparam int DC_BGND_BIT  = 1;
	// Reset values
	localparam logic [1:0]  SYSOPT_RST  = 2'h2;
	localparam logic [31:0] ZERO32      = 32'h0000_0000;
	// Execution start after reset into run mode
	localparam logic [15:0] RUN_START_ADDR = 16'h3FFD;
	// Pin counts
	localparam int NUM_PINS = 28;
	localparam int NUM_LCD  = 22;
	// Background link timing
	localparam logic [4:0] BDC_CYC_PER_BIT = 5'h10;
	localparam logic [4:0] SPEEDUP_CYC     = 5'h02;
	// Clock figures, MHz
	localparam int BUS_CLK_MHZ     = 4;
	localparam int INT_CLK_SRC_MHZ = 8;
	localparam logic [1:0] BUS_DIV_RST = 2'h1;
	// Pin function selector codes
	typedef enum logic [1:0] {
		PMB_FN_PORT = 2'b00,
		PMB_FN_ALT1 = 2'b01,
		PMB_FN_ALT2 = 2'b10,
		PMB_FN_ALT3 = 2'b11
	} pmb_fn_t;
endpackage
`default_nettype wire

// *** rtl/pmb_pin_cell.sv ***
// One pad cell: priority mux of port and three alternate functions
`timescale 1ns/1ps
`default_nettype none
module pmb_pin_cell (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       ce_in,
	// Function enables and per-function drive
	input  wire logic [3:0] fn_en_in,
	input  wire logic [3:0] fn_out_in,
	input  wire logic [3:0] fn_oe_in,
	// Pad options
	input  wire logic       pull_en_in,
	input  wire logic       force_pull_in,
	// Pad
	output logic            pad_out,
	output logic            pad_oe_out,
	output logic            pad_pull_out,
	output pmb_pkg::pmb_fn_t owner_out
);
	pmb_pkg::pmb_fn_t owner_d;

	// Highest enabled function owns the pin; port always enabled as fallback
	always_comb begin
		if (fn_en_in[3]) begin // see [RL14]
			owner_d = pmb_pkg::PMB_FN_ALT3;
		end else if (fn_en_in[2]) begin
			owner_d = pmb_pkg::PMB_FN_ALT2;
		end else if (fn_en_in[1]) begin
			owner_d = pmb_pkg::PMB_FN_ALT1;
		end else begin
			owner_d = pmb_pkg::PMB_FN_PORT;
		end
	end

	// Registered so every pad output comes from a flip-flop
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pad_out      <= 1'b0; // see [RL13]
			pad_oe_out   <= 1'b0;
			pad_pull_out <= 1'b0;
			owner_out    <= pmb_pkg::PMB_FN_PORT;
		end else if (ce_in) begin
			pad_out      <= fn_out_in[owner_d];
			pad_oe_out   <= fn_oe_in[owner_d];
			pad_pull_out <= (pull_en_in & ~fn_oe_in[owner_d]) | force_pull_in; // see [RL4]
			owner_out    <= owner_d;
		end
	end
endmodule
`default_nettype wire

// *** rtl/pmb_pin_mux_boot.sv ***
// Top: pin mux, reset-pin option, mode select capture and background pin link
//
// What this block and its software do
// [RL1] Shared reset pin comes up as input
// [RL2] Reset enable bit latches pin as reset
// [RL3] Low on enabled reset pin resets device
// [RL4] Reset enable forces pin pullup on
// [RL5] Mode select at reset, debug after
// [RL6] Background enable set on every reset
// [RL7] Low mode select enters background mode
// [RL8] High mode select runs from 3FFD
// [RL9] Sixteen debug clocks per link bit
// [RL10] Open drain with driven speedup pulses
// [RL11] LCD pins high-Z, GPIO by default
// [RL12] Pullup per pin; drive strength and slew one bit each, applied to pins set as outputs
// [RL13] Reset leaves pins hi-Z inputs, no pullup except on the mode/debug pin
// [RL14] Highest enabled function owns pin
// [RL15] Software disables old function first
// [RL16] Software puts jump at start location
// [RL17] Reset clocking gives 4 MHz bus
// [RL18] Command, instruction, breakpoint enter background
// [RL19] Mode select captured at reset release
`timescale 1ns/1ps
`default_nettype none
module pmb_pin_mux_boot (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Pads: 28 pins, pin 8 is the shared reset pin, pin 9 the mode/debug pin
	input  wire logic [27:0] pad_in,
	output logic [27:0]      pad_out,
	output logic [27:0]      pad_oe_out,
	output logic [27:0]      pad_pull_out,
	output logic [27:0]      pad_high_drive_out,
	output logic [27:0]      pad_slew_out,
	// Peripheral alternate functions
	input  wire logic [27:0] alt1_en_in,
	input  wire logic [27:0] alt2_en_in,
	input  wire logic [27:0] alt2_out_in,
	input  wire logic [27:0] alt2_oe_in,
	input  wire logic [27:0] alt3_out_in,
	input  wire logic [27:0] alt3_oe_in,
	// Debug core events and background link bit requests
	input  wire logic        bgnd_instr_in,
	input  wire logic        breakpoint_in,
	input  wire logic        bdc_tx_req_in,
	input  wire logic        bdc_tx_bit_in,
	// System status
	output logic             ext_reset_req_out,
	output logic             bkg_mode_out,
	output logic             run_start_out,
	output logic [15:0]      start_addr_out,
	output logic [1:0]       bus_div_out,
	output logic             bdc_tx_busy_out
);
	localparam int RST_PIN = 8;
	localparam int MS_PIN  = 9;

	// ==========================================================
	// Registers
	logic [1:0]  sysopt_q;
	logic [27:0] lcd_sel_q;
	logic [27:0] pull_q;
	logic [27:0] hdrv_q;
	logic [27:0] slew_q;
	logic [27:0] port_out_q;
	logic [27:0] port_dir_q;
	logic        ms_sync1_q;
	logic        ms_sync2_q;
	logic        in_reset_q;
	logic        ms_capt_q;
	logic        bkg_q;
	logic        rst_pin_sync1_q;
	logic        rst_pin_sync2_q;
	logic [4:0]  bit_cnt_q;
	logic        tx_bit_q;
	logic        link_drive_q;
	logic        link_level_q;

	logic apb_acc;
	logic apb_wr;
	logic cmd_bgnd;
	logic cmd_go;
	assign apb_acc  = psel_in & penable_in;
	assign apb_wr   = apb_acc & pwrite_in;
	assign cmd_bgnd = apb_wr & (paddr_in == pmb_pkg::DBGCMD_OFF) & pwdata_in[pmb_pkg::DC_BGND_BIT];
	assign cmd_go   = apb_wr & (paddr_in == pmb_pkg::DBGCMD_OFF) & pwdata_in[pmb_pkg::DC_GO_BIT];

	// ==========================================================
	// APB slave, zero wait states
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sysopt_q   <= pmb_pkg::SYSOPT_RST; // see [RL6]
			lcd_sel_q  <= pmb_pkg::ZERO32[27:0]; // see [RL11]
			pull_q     <= pmb_pkg::ZERO32[27:0];
			hdrv_q     <= pmb_pkg::ZERO32[27:0];
			slew_q     <= pmb_pkg::ZERO32[27:0];
			port_out_q <= pmb_pkg::ZERO32[27:0];
			port_dir_q <= pmb_pkg::ZERO32[27:0]; // see [RL13]
		end else if (ce_in && apb_wr) begin
			unique case (paddr_in)
				pmb_pkg::SYSOPT_OFF: begin
					// Reset enable is write-once-set: only a reset clears it
					sysopt_q[pmb_pkg::RST_PIN_EN_BIT] <= sysopt_q[pmb_pkg::RST_PIN_EN_BIT]
						| pwdata_in[pmb_pkg::RST_PIN_EN_BIT]; // see [RL2]
					sysopt_q[pmb_pkg::BKG_PIN_EN_BIT] <= pwdata_in[pmb_pkg::BKG_PIN_EN_BIT];
				end
				pmb_pkg::FUNCSEL_OFF: lcd_sel_q <= pwdata_in[27:0];
				pmb_pkg::PADCFG_OFF: begin
					// Bits 27:0 pull only; drive and slew are written at the status offset
					pull_q <= pwdata_in[27:0]; // see [RL12]
				end
				pmb_pkg::PORTOUT_OFF: port_out_q <= pwdata_in[27:0];
				pmb_pkg::PORTDIR_OFF: port_dir_q <= pwdata_in[27:0];
				pmb_pkg::STATUS_OFF: begin
					// Drive strength and slew share this offset as write-only
					hdrv_q <= {28{pwdata_in[0]}} & port_dir_q; // see [RL12]
					slew_q <= {28{pwdata_in[1]}} & port_dir_q;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out  <= pmb_pkg::ZERO32;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else if (ce_in) begin
			pready_out  <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & (paddr_in > pmb_pkg::DBGCMD_OFF);
			unique case (paddr_in)
				pmb_pkg::SYSOPT_OFF:  prdata_out <= {30'h0, sysopt_q};
				pmb_pkg::STATUS_OFF:  prdata_out <= {29'h0, rst_pin_sync2_q, ms_capt_q, bkg_q};
				pmb_pkg::FUNCSEL_OFF: prdata_out <= {4'h0, lcd_sel_q};
				pmb_pkg::PADCFG_OFF:  prdata_out <= {4'h0, pull_q};
				pmb_pkg::PORTOUT_OFF: prdata_out <= {4'h0, port_out_q};
				pmb_pkg::PORTDIR_OFF: prdata_out <= {4'h0, port_dir_q};
				pmb_pkg::PORTIN_OFF:  prdata_out <= {4'h0, pad_in};
				default:              prdata_out <= pmb_pkg::ZERO32;
			endcase
		end
	end

	// ==========================================================
	// Reset pin and mode select capture
	// Mode pin synchroniser has no reset: it tracks the pin while reset
	// is held, so the level is settled at the release edge
	always_ff @(posedge sys_clk_in) begin
		if (ce_in) begin
			ms_sync1_q <= pad_in[MS_PIN];
			ms_sync2_q <= ms_sync1_q; // see [RL19]
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_pin_sync1_q <= 1'b1;
			rst_pin_sync2_q <= 1'b1;
			in_reset_q      <= 1'b1;
			ms_capt_q       <= 1'b1;
		end else if (ce_in) begin
			rst_pin_sync1_q <= pad_in[RST_PIN];
			rst_pin_sync2_q <= rst_pin_sync1_q;
			in_reset_q      <= 1'b0;
			if (in_reset_q) begin
				// Level only captured on the first cycle after release
				ms_capt_q <= ms_sync2_q; // see [RL5] [RL19]
			end
		end
	end

	// Reset request only while pin is configured as reset input
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_reset_req_out <= 1'b0;
		end else if (ce_in) begin
			ext_reset_req_out <= sysopt_q[pmb_pkg::RST_PIN_EN_BIT] & ~rst_pin_sync2_q; // see [RL3]
		end
	end

	// ==========================================================
	// Operating mode
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bkg_q          <= 1'b0;
			run_start_out  <= 1'b0;
			start_addr_out <= pmb_pkg::RUN_START_ADDR;
			bus_div_out    <= pmb_pkg::BUS_DIV_RST; // see [RL17]
		end else if (ce_in) begin
			run_start_out <= 1'b0;
			if (in_reset_q) begin
				bkg_q         <= ~ms_sync2_q; // see [RL7]
				run_start_out <= ms_sync2_q; // see [RL8]
			end else if (cmd_bgnd || bgnd_instr_in || breakpoint_in) begin
				bkg_q <= 1'b1; // see [RL18]
			end else if (cmd_go) begin
				bkg_q <= 1'b0;
			end
		end
	end
	assign bkg_mode_out = bkg_q;

	// ==========================================================
	// Background link bit timer, pseudo open drain
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_cnt_q       <= 5'h00;
			tx_bit_q        <= 1'b1;
			link_drive_q    <= 1'b0;
			link_level_q    <= 1'b1;
			bdc_tx_busy_out <= 1'b0;
		end else if (ce_in) begin
			if (bit_cnt_q == 5'h00) begin
				link_drive_q <= 1'b0;
				if (bdc_tx_req_in && sysopt_q[pmb_pkg::BKG_PIN_EN_BIT] && !in_reset_q) begin
					bit_cnt_q       <= pmb_pkg::BDC_CYC_PER_BIT; // see [RL9]
					tx_bit_q        <= bdc_tx_bit_in;
					link_drive_q    <= 1'b1;
					link_level_q    <= 1'b0;
					bdc_tx_busy_out <= 1'b1;
				end
			end else begin
				bit_cnt_q       <= bit_cnt_q - 5'h01;
				bdc_tx_busy_out <= bit_cnt_q != 5'h01;
				if (!link_level_q && ((bit_cnt_q == pmb_pkg::BDC_CYC_PER_BIT - 5'h04 && tx_bit_q)
						|| bit_cnt_q == pmb_pkg::SPEEDUP_CYC + 5'h01)) begin
					// Still driven for one cycle: the high speedup pulse
					link_level_q <= 1'b1; // see [RL10]
				end else if (link_level_q) begin
					// Released after the pulse, the pullup holds the line high
					link_drive_q <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Per-pin function mux
	genvar gi;
	generate
		for (gi = 0; gi < pmb_pkg::NUM_PINS; gi++) begin : g_pin
			logic [3:0] fn_en;
			logic [3:0] fn_out;
			logic [3:0] fn_oe;
			logic       force_pull;
			if (gi == RST_PIN) begin : g_rst
				// Reset function overrides everything once enabled; input only
				assign fn_en  = {1'b0, sysopt_q[pmb_pkg::RST_PIN_EN_BIT], alt1_en_in[gi], 1'b1}; // see [RL1] [RL2]
				assign fn_out = 4'h0;
				assign fn_oe  = 4'h0;
				assign force_pull = sysopt_q[pmb_pkg::RST_PIN_EN_BIT]; // see [RL4]
			end else if (gi == MS_PIN) begin : g_ms
				assign fn_en  = {1'b0, sysopt_q[pmb_pkg::BKG_PIN_EN_BIT], 1'b0, 1'b1}; // see [RL5] [RL6]
				assign fn_out = {1'b0, link_level_q, 1'b0, port_out_q[gi]};
				assign fn_oe  = {1'b0, link_drive_q, 1'b0, port_dir_q[gi]}; // see [RL10]
				assign force_pull = sysopt_q[pmb_pkg::BKG_PIN_EN_BIT];
			end else begin : g_gen
				assign fn_en  = {lcd_sel_q[gi], alt2_en_in[gi], alt1_en_in[gi], 1'b1}; // see [RL11] [RL14]
				assign fn_out = {alt3_out_in[gi], alt2_out_in[gi], 1'b0, port_out_q[gi]};
				assign fn_oe  = {alt3_oe_in[gi], alt2_oe_in[gi], 1'b0, port_dir_q[gi]};
				assign force_pull = 1'b0;
			end
			pmb_pin_cell u_cell (
				.clk_in        (sys_clk_in),
				.rst_in        (rst_in),
				.ce_in         (ce_in),
				.fn_en_in      (fn_en),
				.fn_out_in     (fn_out),
				.fn_oe_in      (fn_oe),
				.pull_en_in    (pull_q[gi]),
				.force_pull_in (force_pull),
				.pad_out       (pad_out[gi]),
				.pad_oe_out    (pad_oe_out[gi]),
				.pad_pull_out  (pad_pull_out[gi]),
				.owner_out     ()
			);
		end
	endgenerate
	assign pad_high_drive_out = hdrv_q;
	assign pad_slew_out       = slew_q;

	// ==========================================================
	// Assertions
	a_rst_en_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$past(sysopt_q[0]) |-> sysopt_q[0]) else $error("reset enable cleared"); // see [RL2]
	a_ext_reset_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && !sysopt_q[0] |=> !ext_reset_req_out) else $error("reset without enable"); // see [RL3]
	a_pull_forced: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && sysopt_q[0] |=> pad_pull_out[RST_PIN]) else $error("reset pullup off"); // see [RL4]
	a_mode_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		in_reset_q && ce_in && !ms_sync2_q |=> bkg_q && !run_start_out) else $error("no bkg"); // see [RL7]
	a_mode_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		in_reset_q && ce_in && ms_sync2_q |=> run_start_out && start_addr_out == 16'h3FFD)
		else $error("no run start"); // see [RL8]
	a_bit_time: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(bdc_tx_busy_out) && ce_in |-> bit_cnt_q == 5'h10) else $error("bit time"); // see [RL9]
	a_rst_pin_input: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		sysopt_q[0] && $past(sysopt_q[0]) |-> !pad_oe_out[RST_PIN]) else $error("reset pin driven"); // see [RL1]
	a_bkg_event: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && !in_reset_q && (bgnd_instr_in || breakpoint_in) |=> bkg_q) else $error("no bkg event"); // see [RL18]
	c_run_mode: cover property (@(posedge sys_clk_in) run_start_out);
	c_bkg_boot: cover property (@(posedge sys_clk_in) $rose(bkg_q));
	c_ext_reset: cover property (@(posedge sys_clk_in) ext_reset_req_out);
	c_link_bit: cover property (@(posedge sys_clk_in) $rose(bdc_tx_busy_out));
endmodule
`default_nettype wire

// *** testbench/pmb_host_model.sv ***
// Far-side model: external reset source and background debug host
`timescale 1ns/1ps
`default_nettype none
module pmb_host_model (
	// Host requests from the bench
	input  wire logic hold_mode_low_in,
	input  wire logic pull_reset_low_in,
	// Device drive of the two shared pins
	input  wire logic rst_pin_oe_in,
	input  wire logic rst_pin_out_in,
	input  wire logic mode_pin_oe_in,
	input  wire logic mode_pin_out_in,
	// Resolved wire levels
	output logic      rst_pin_lvl_out,
	output logic      mode_pin_lvl_out
);
	// ==========================================================
	// Wire resolution
	// Host only pulls low, so a low always wins over a driven high;
	// board pull-ups supply the released level
	always_comb begin
		rst_pin_lvl_out  = !pull_reset_low_in && (!rst_pin_oe_in || rst_pin_out_in);
		mode_pin_lvl_out = !hold_mode_low_in && (!mode_pin_oe_in || mode_pin_out_in);
	end
endmodule
`default_nettype wire

// *** testbench/pmb_pin_mux_boot_bench.sv ***
// Self-checking bench for the pin mux and boot mode block
`timescale 1ns/1ps
`default_nettype none
module pmb_pin_mux_boot_bench;
	// ==========================================================
	// Signals
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic        pready, pslverr, errv;
	logic [27:0] pad_in, pad_out, pad_oe, pad_pull, pad_hd, pad_slew, lvl;
	logic [27:0] alt1_en = '0, alt2_en = '0, alt2_out = '0, alt2_oe = '0;
	logic [27:0] alt3_out = '0, alt3_oe = '0;
	logic        bgnd = 1'b0, brk = 1'b0, tx_req = 1'b0, tx_bit = 1'b0;
	logic        ext_rst, bkg_mode, run_start, tx_busy, saw_run;
	logic [15:0] start_addr;
	logic [1:0]  bus_div;
	logic        host_mode_low = 1'b0, host_rst_low = 1'b0, pin8, pin9, saw_lo;
	logic        ce = 1'b1;
	int          failures = 0, n_compared = 0, n, n_hi;

	always #4 clk = ~clk;

	// Undriven pins float to a pull level or read low
	assign lvl    = (pad_oe & pad_out) | (~pad_oe & pad_pull);
	assign pad_in = {lvl[27:10], pin9, pin8, lvl[7:0]};

	always @(posedge clk) begin
		if (rst)
			saw_run <= 1'b0;
		else if (run_start === 1'b1)
			saw_run <= 1'b1;
	end

	pmb_pin_mux_boot u_pmb_pin_mux_boot (.sys_clk_in(clk), .rst_in(rst), .ce_in(ce),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe), .pad_pull_out(pad_pull),
		.pad_high_drive_out(pad_hd), .pad_slew_out(pad_slew), .alt1_en_in(alt1_en),
		.alt2_en_in(alt2_en), .alt2_out_in(alt2_out), .alt2_oe_in(alt2_oe),
		.alt3_out_in(alt3_out), .alt3_oe_in(alt3_oe), .bgnd_instr_in(bgnd),
		.breakpoint_in(brk), .bdc_tx_req_in(tx_req), .bdc_tx_bit_in(tx_bit),
		.ext_reset_req_out(ext_rst), .bkg_mode_out(bkg_mode), .run_start_out(run_start),
		.start_addr_out(start_addr), .bus_div_out(bus_div), .bdc_tx_busy_out(tx_busy));

	pmb_host_model u_pmb_host_model (.hold_mode_low_in(host_mode_low),
		.pull_reset_low_in(host_rst_low), .rst_pin_oe_in(pad_oe[8]),
		.rst_pin_out_in(pad_out[8]), .mode_pin_oe_in(pad_oe[9]),
		.mode_pin_out_in(pad_out[9]), .rst_pin_lvl_out(pin8), .mode_pin_lvl_out(pin9));

	// ==========================================================
	// Tasks
	task automatic complete_run();
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge clk);
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		// Answer is taken at the rising edge where pready is sampled high
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			failures++;
			complete_run();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_reset(input logic mode_low);
		@(posedge clk);
		rst <= 1'b1;
		host_mode_low <= mode_low;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// Captured mode must not follow the pin after release
		host_mode_low <= 1'b0;
		settle(2);
	endtask

	task automatic pulse(input int which);
		@(posedge clk);
		if (which == 0)
			bgnd <= 1'b1;
		else
			brk <= 1'b1;
		@(posedge clk);
		bgnd <= 1'b0;
		brk <= 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

	// ==========================================================
	// Scenarios
	initial begin
		do_reset(1'b0);
		chk("run_start", 32'h1, 32'(saw_run));
		chk("bkg_mode", 32'h0, 32'(bkg_mode));
		chk("start_addr", 32'h3FFD, 32'(start_addr));
		chk("bus_div", 32'(pmb_pkg::BUS_DIV_RST), 32'(bus_div));
		chk("pad_oe", 32'h0, 32'(pad_oe));
		// Only the mode/debug pin keeps a pullup while it is the background pin
		chk("pad_pull", 32'h0000_0200, 32'(pad_pull));
		apb(1'b0, pmb_pkg::SYSOPT_OFF, 32'h0);
		chk("sysopt", 32'h2, rdv);
		apb(1'b0, pmb_pkg::FUNCSEL_OFF, 32'h0);
		chk("funcsel", 32'h0, rdv);
		apb(1'b0, pmb_pkg::STATUS_OFF, 32'h0);
		chk("mode_capt", 32'h2, rdv & 32'h3);
		// Shared reset pin
		host_rst_low <= 1'b1;
		settle(5);
		chk("ext_rst_off", 32'h0, 32'(ext_rst));
		host_rst_low <= 1'b0;
		apb(1'b1, pmb_pkg::SYSOPT_OFF, 32'h3);
		settle(2);
		chk("rst_pull", 32'h1, 32'(pad_pull[8]));
		apb(1'b1, pmb_pkg::SYSOPT_OFF, 32'h2);
		apb(1'b0, pmb_pkg::SYSOPT_OFF, 32'h0);
		chk("rst_sticky", 32'h3, rdv);
		host_rst_low <= 1'b1;
		settle(5);
		chk("ext_rst_on", 32'h1, 32'(ext_rst));
		host_rst_low <= 1'b0;
		apb(1'b1, 8'h20, 32'h1);
		chk("slverr", 32'h1, 32'(errv));
		// Debug host holds mode pin low
		do_reset(1'b1);
		chk("bkg_entry", 32'h1, 32'(bkg_mode));
		chk("no_run", 32'h0, 32'(saw_run));
		apb(1'b0, pmb_pkg::SYSOPT_OFF, 32'h0);
		chk("sysopt_rst", 32'h2, rdv);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, pmb_pkg::DBGCMD_OFF, 32'h1);
			settle(2);
			chk("go", 32'h0, 32'(bkg_mode));
			if (k < 2)
				pulse(k);
			else
				apb(1'b1, pmb_pkg::DBGCMD_OFF, 32'h2);
			settle(2);
			chk("bkg_event", 32'h1, 32'(bkg_mode));
		end
		// Clock enable low freezes the mode flag against a breakpoint
		apb(1'b1, pmb_pkg::DBGCMD_OFF, 32'h1);
		ce <= 1'b0;
		pulse(1);
		settle(2);
		ce <= 1'b1;
		chk("ce_hold", 32'h0, 32'(bkg_mode));
		// One link bit of each value; the high pulse must stay brief
		for (int b = 0; b < 2; b++) begin
			@(posedge clk);
			tx_req <= 1'b1;
			tx_bit <= b[0];
			@(posedge clk);
			tx_req <= 1'b0;
			n = 0;
			n_hi = 0;
			saw_lo = 1'b0;
			for (int i = 0; i < 40; i++) begin
				@(negedge clk);
				if (tx_busy === 1'b1)
					n++;
				if (pad_oe[9] === 1'b1 && pad_out[9] === 1'b0)
					saw_lo = 1'b1;
				if (pad_oe[9] === 1'b1 && pad_out[9] === 1'b1)
					n_hi++;
			end
			chk("bit_len", 32'h10, 32'(n));
			chk("drive_low", 32'h1, 32'(saw_lo));
			chk("speedup", 32'h1, 32'(n_hi));
			chk("released", 32'h0, 32'(pad_oe[9]));
		end
		// Function priority on pin 0
		apb(1'b1, pmb_pkg::PORTDIR_OFF, 32'h1);
		apb(1'b1, pmb_pkg::PORTOUT_OFF, 32'h1);
		settle(3);
		chk("port_own", 32'h3, {30'h0, pad_oe[0], pad_out[0]});
		@(posedge clk);
		alt1_en[0] <= 1'b1;
		alt2_en[0] <= 1'b1;
		alt2_oe[0] <= 1'b1;
		alt3_oe[0] <= 1'b1;
		alt3_out[0] <= 1'b1;
		settle(3);
		chk("alt2_own", 32'h2, {30'h0, pad_oe[0], pad_out[0]});
		apb(1'b1, pmb_pkg::FUNCSEL_OFF, 32'h1);
		settle(3);
		chk("alt3_own", 32'h3, {30'h0, pad_oe[0], pad_out[0]});
		// Pad options
		apb(1'b1, pmb_pkg::STATUS_OFF, 32'h3);
		apb(1'b1, pmb_pkg::PADCFG_OFF, 32'h3);
		settle(3);
		chk("drive_opt", 32'h3, {30'h0, pad_hd[0], pad_slew[0]});
		chk("pull_opt", 32'h2, {30'h0, pad_pull[1], pad_pull[0]});
		complete_run();
	end
endmodule
`default_nettype wire
